//--- logic/fsctl_top.sv
/*
  Host-side flash sequencer: AHB-Lite registers, command and status
  cycles, high-voltage mode control for protect, verify and unprotect.
  Assumes one AHB master, OKAY-only answers, and external high-voltage
  switches driven by hv_a9, hv_oe and hv_reset.
*/
// Our own choices: the AHB-Lite slave port and the placing of the registers.
// Notes on behaviour
// - Host reads the window flag before and after each added erase command.
// - Writes only with chip select and write strobe low, output enable high.
// - High voltage on the reset pin gives temporary unprotect.
// - Sector protect pulses write strobe with high voltage on bit nine and enable.
// - Chip unprotect pulses strobe with high voltage, chip select low, bit six high.
// - Protect every sector before starting chip unprotect; the code only needs one protect since the last unprotect.
`timescale 1ns/1ps
`include "fsctl_consts.svh"

module fsctl_top #(
  parameter int PROT_CYC = `FSCTL_CEIL_CYC(`FSCTL_PROT_PULSE_NS),
  parameter int HV_CYC   = `FSCTL_CEIL_CYC(`FSCTL_HV_SETUP_NS)
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  output fsctl_pkg::fsctl_bus_t      flash_bus,
  input  wire logic [`FSCTL_DW-1:0]  dq_i,
  output logic                       hv_a9,
  output logic                       hv_oe,
  output logic                       hv_reset
);

  localparam int WP_CYC  = `FSCTL_CEIL_CYC(`FSCTL_WP_NS);
  localparam int ACC_CYC = `FSCTL_CEIL_CYC(`FSCTL_ACC_NS);

  fsctl_pkg::fsctl_state_t  state_q, state_d;
  fsctl_pkg::fsctl_op_t     op_q, op_d;
  fsctl_pkg::fsctl_req_t    req;
  logic [`FSCTL_AW-1:0]     addr_q;
  logic [`FSCTL_DW-1:0]     wdata_q;
  logic [`FSCTL_DW-1:0]     rdata;
  logic [`FSCTL_CW-1:0]     hv_cnt_q, hv_cnt_d;
  logic                     reject_q, reject_d;
  logic                     primed_q, primed_d;
  logic                     mode_temp_q;
  logic                     hv_a9_q, hv_oe_q;
  logic                     wr_q;
  logic [`FSCTL_OFF_W-1:0]  wa_q;
  logic [31:0]              hrdata_q;
  logic                     cyc_start;
  logic                     cyc_done;
  logic                     cyc_idle;

  // ----------------------------------------------------------------
  // AHB-Lite slave decode
  // ----------------------------------------------------------------
  wire                     ap_valid = hsel && htrans[`FSCTL_HTRANS_ACT] && hready;
  wire [`FSCTL_OFF_W-1:0]  ap_off   = haddr[`FSCTL_OFF_W-1:0];
  wire                     wr_ctrl  = wr_q && (wa_q == `FSCTL_REG_CTRL);
  wire                     wr_addr  = wr_q && (wa_q == `FSCTL_REG_ADDR);
  wire                     wr_wdata = wr_q && (wa_q == `FSCTL_REG_WDATA);
  wire                     wr_mode  = wr_q && (wa_q == `FSCTL_REG_MODE);
  wire [2:0]               op_raw   = hwdata[`FSCTL_CTRL_OP_MSB:`FSCTL_CTRL_OP_LSB];
  wire                     go       = wr_ctrl && hwdata[`FSCTL_CTRL_GO]
                                      && (state_q == fsctl_pkg::S_IDLE);
  wire                     op_legal = op_raw <= 3'(fsctl_pkg::OP_UNPROTECT);
  wire                     busy     = (state_q != fsctl_pkg::S_IDLE) || !cyc_idle;
  wire [31:0]              status   = {28'h0000000, mode_temp_q, primed_q, reject_q, busy};
  wire [31:0]              rd_mux   =
      (ap_off == `FSCTL_REG_CTRL)   ? {29'h00000000, 3'(op_q)} :
      (ap_off == `FSCTL_REG_ADDR)   ? {12'h000, addr_q} :
      (ap_off == `FSCTL_REG_WDATA)  ? {16'h0000, wdata_q} :
      (ap_off == `FSCTL_REG_RDATA)  ? {16'h0000, rdata} :
      (ap_off == `FSCTL_REG_STATUS) ? status :
      (ap_off == `FSCTL_REG_MODE)   ? {31'h00000000, mode_temp_q} : 32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ----------------------------------------------------------------
  // Pin cycle request
  // ----------------------------------------------------------------
  wire is_hv_op  = (op_q == fsctl_pkg::OP_PROTECT) || (op_q == fsctl_pkg::OP_UNPROTECT)
                   || (op_q == fsctl_pkg::OP_VERIFY);
  wire is_pulse  = (op_q == fsctl_pkg::OP_PROTECT) || (op_q == fsctl_pkg::OP_UNPROTECT);
  wire q3_high   = rdata[`FSCTL_Q3];
  wire [`FSCTL_AW-1:0] addr_vfy = {addr_q[`FSCTL_AW-1:`FSCTL_A6+1], 1'b0,
                                   addr_q[`FSCTL_A6-1:`FSCTL_A1+1], 2'b10};
  wire [`FSCTL_AW-1:0] addr_unp = addr_q | (`FSCTL_AW'(1) << `FSCTL_A6);
  wire [`FSCTL_AW-1:0] addr_eff =
      (op_q == fsctl_pkg::OP_VERIFY)    ? addr_vfy :
      (op_q == fsctl_pkg::OP_UNPROTECT) ? addr_unp : addr_q;
  wire wr_state  = state_d == fsctl_pkg::S_WR;

  assign req.is_write   = wr_state;
  assign req.addr       = addr_eff;
  assign req.wdata      = wdata_q;
  assign req.strobe_len = wr_state ? (is_pulse ? `FSCTL_CW'(PROT_CYC) : `FSCTL_CW'(WP_CYC))
                                   : `FSCTL_CW'(ACC_CYC);

  fsctl_cycle u_cycle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (cyc_start),
    .req     (req),
    .dq_i    (dq_i),
    .bus     (flash_bus),
    .rdata   (rdata),
    .done    (cyc_done),
    .idle    (cyc_idle)
  );

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    op_d      = op_q;
    hv_cnt_d  = hv_cnt_q;
    reject_d  = reject_q;
    primed_d  = primed_q;
    cyc_start = 1'b0;
    unique case (state_q)
      fsctl_pkg::S_IDLE: begin
        if (go) begin
          reject_d = 1'b0;
          op_d     = fsctl_pkg::fsctl_op_t'(op_raw);
          if (!op_legal) begin
            reject_d = 1'b1;
          end else if (op_d == fsctl_pkg::OP_UNPROTECT && !primed_q) begin
            reject_d = 1'b1;
          end else if (op_d == fsctl_pkg::OP_READ) begin
            state_d   = fsctl_pkg::S_RD;
            cyc_start = 1'b1;
          end else if (op_d == fsctl_pkg::OP_WRITE) begin
            state_d   = fsctl_pkg::S_WR;
            cyc_start = 1'b1;
          end else if (op_d == fsctl_pkg::OP_ERASE_ADD) begin
            state_d   = fsctl_pkg::S_CHK1;
            cyc_start = 1'b1;
          end else begin
            state_d  = fsctl_pkg::S_HV_ON;
            hv_cnt_d = `FSCTL_CW'(HV_CYC);
          end
        end
      end
      fsctl_pkg::S_HV_ON: begin
        if (hv_cnt_q <= `FSCTL_CW'(1)) begin
          state_d   = (op_q == fsctl_pkg::OP_VERIFY) ? fsctl_pkg::S_RD : fsctl_pkg::S_WR;
          cyc_start = 1'b1;
        end else begin
          hv_cnt_d = hv_cnt_q - `FSCTL_CW'(1);
        end
      end
      fsctl_pkg::S_CHK1: begin
        if (cyc_done) begin
          if (q3_high) begin
            reject_d = 1'b1;
            state_d  = fsctl_pkg::S_IDLE;
          end else begin
            state_d   = fsctl_pkg::S_WR;
            cyc_start = 1'b1;
          end
        end
      end
      fsctl_pkg::S_WR: begin
        if (cyc_done) begin
          if (op_q == fsctl_pkg::OP_ERASE_ADD) begin
            state_d   = fsctl_pkg::S_CHK2;
            cyc_start = 1'b1;
          end else if (is_hv_op) begin
            state_d  = fsctl_pkg::S_HV_OFF;
            hv_cnt_d = `FSCTL_CW'(HV_CYC);
            primed_d = op_q == fsctl_pkg::OP_PROTECT;
          end else begin
            state_d = fsctl_pkg::S_IDLE;
          end
        end
      end
      fsctl_pkg::S_CHK2: begin
        if (cyc_done) begin
          reject_d = q3_high;
          state_d  = fsctl_pkg::S_IDLE;
        end
      end
      fsctl_pkg::S_RD: begin
        if (cyc_done) begin
          state_d  = is_hv_op ? fsctl_pkg::S_HV_OFF : fsctl_pkg::S_IDLE;
          hv_cnt_d = `FSCTL_CW'(HV_CYC);
        end
      end
      fsctl_pkg::S_HV_OFF: begin
        if (hv_cnt_q <= `FSCTL_CW'(1)) begin
          state_d = fsctl_pkg::S_IDLE;
        end else begin
          hv_cnt_d = hv_cnt_q - `FSCTL_CW'(1);
        end
      end
    endcase
  end

  wire hv_span = (state_d != fsctl_pkg::S_IDLE) && (state_d != fsctl_pkg::S_HV_OFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= fsctl_pkg::S_IDLE;
      op_q     <= fsctl_pkg::OP_READ;
      hv_cnt_q <= '0;
      reject_q <= 1'b0;
      primed_q <= 1'b0;
      hv_a9_q  <= 1'b0;
      hv_oe_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      op_q     <= op_d;
      hv_cnt_q <= hv_cnt_d;
      reject_q <= reject_d;
      primed_q <= primed_d;
      hv_a9_q  <= hv_span && (op_d == fsctl_pkg::OP_PROTECT || op_d == fsctl_pkg::OP_VERIFY
                              || op_d == fsctl_pkg::OP_UNPROTECT);
      hv_oe_q  <= hv_span && (op_d == fsctl_pkg::OP_PROTECT || op_d == fsctl_pkg::OP_UNPROTECT);
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q        <= 1'b0;
      wa_q        <= '0;
      hrdata_q    <= '0;
      addr_q      <= '0;
      wdata_q     <= '0;
      mode_temp_q <= 1'b0;
    end else begin
      wr_q <= ap_valid && hwrite;
      wa_q <= ap_off;
      if (ap_valid && !hwrite) begin
        hrdata_q <= rd_mux;
      end
      if (wr_addr) begin
        addr_q <= hwdata[`FSCTL_AW-1:0];
      end
      if (wr_wdata) begin
        wdata_q <= hwdata[`FSCTL_DW-1:0];
      end
      if (wr_mode) begin
        mode_temp_q <= hwdata[`FSCTL_MODE_TEMP];
      end
    end
  end

  assign hv_a9    = hv_a9_q;
  assign hv_oe    = hv_oe_q;
  assign hv_reset = mode_temp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_chk1_busy;
    state_q == fsctl_pkg::S_CHK1 && cyc_done && q3_high;
  endsequence

  sequence s_erase_wr_done;
    state_q == fsctl_pkg::S_WR && op_q == fsctl_pkg::OP_ERASE_ADD && cyc_done;
  endsequence

  property p_q3_skip;
    @(posedge hclk) disable iff (!hresetn)
      s_chk1_busy |=> reject_q && state_q == fsctl_pkg::S_IDLE && flash_bus.we_n [*3];
  endproperty
  a_q3_skip: assert property (p_q3_skip) else $error("erase sent despite open flag");

  property p_q3_recheck;
    @(posedge hclk) disable iff (!hresetn)
      s_erase_wr_done |=> state_q == fsctl_pkg::S_CHK2 ##1 !flash_bus.ce_n ##1 !flash_bus.oe_n;
  endproperty
  a_q3_recheck: assert property (p_q3_recheck) else $error("no flag check after erase");

  property p_prot_hv;
    @(posedge hclk) disable iff (!hresetn)
      $fell(flash_bus.we_n) && op_q == fsctl_pkg::OP_PROTECT
        |-> hv_a9 && hv_oe && $past(hv_a9, 3);
  endproperty
  a_prot_hv: assert property (p_prot_hv) else $error("protect pulse without high voltage");

  property p_unprot_pins;
    @(posedge hclk) disable iff (!hresetn)
      !flash_bus.we_n && op_q == fsctl_pkg::OP_UNPROTECT
        |-> hv_a9 && hv_oe && !flash_bus.ce_n && flash_bus.addr[`FSCTL_A6];
  endproperty
  a_unprot_pins: assert property (p_unprot_pins) else $error("unprotect pins wrong");

  property p_temp_mode;
    @(posedge hclk) disable iff (!hresetn)
      wr_mode |=> hv_reset == $past(hwdata[`FSCTL_MODE_TEMP]);
  endproperty
  a_temp_mode: assert property (p_temp_mode) else $error("reset high voltage not set");

  property p_unprot_prime;
    @(posedge hclk) disable iff (!hresetn)
      go && op_legal && op_raw == 3'(fsctl_pkg::OP_UNPROTECT) && !primed_q
        |=> reject_q && state_q == fsctl_pkg::S_IDLE ##1 !hv_oe;
  endproperty
  a_unprot_prime: assert property (p_unprot_prime) else $error("unprimed unprotect ran");

endmodule // fsctl_top

//--- common/fsctl_consts.svh
/*
  Named constants of the flash sequencing controller: pin widths, timing
  figures, register offsets and field positions.
  Assumes a 50 MHz hclk; included by the package and by the design files.
*/
`ifndef FSCTL_CONSTS_SVH
`define FSCTL_CONSTS_SVH

// ----------------------------------------------------------------
// Pin and counter widths and clock
// ----------------------------------------------------------------
`define FSCTL_AW            20
`define FSCTL_DW            16
`define FSCTL_CW            16
`define FSCTL_CLK_NS        20

// ----------------------------------------------------------------
// Timing figures in ns
// ----------------------------------------------------------------
`define FSCTL_WP_NS         35
`define FSCTL_AH_NS         45
`define FSCTL_ACC_NS        90
`define FSCTL_HV_SETUP_NS   4000
`define FSCTL_PROT_PULSE_NS 100000
`define FSCTL_CEIL_CYC(ns)  (((ns) + `FSCTL_CLK_NS - 1) / `FSCTL_CLK_NS)

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define FSCTL_OFF_W         8
`define FSCTL_REG_CTRL      8'h00
`define FSCTL_REG_ADDR      8'h04
`define FSCTL_REG_WDATA     8'h08
`define FSCTL_REG_RDATA     8'h0C
`define FSCTL_REG_STATUS    8'h10
`define FSCTL_REG_MODE      8'h14
`define FSCTL_CTRL_GO       8
`define FSCTL_CTRL_OP_LSB   0
`define FSCTL_CTRL_OP_MSB   2
`define FSCTL_ST_BUSY       0
`define FSCTL_ST_REJECT     1
`define FSCTL_ST_PRIMED     2
`define FSCTL_ST_TEMP       3
`define FSCTL_MODE_TEMP     0
`define FSCTL_HTRANS_ACT    1

// ----------------------------------------------------------------
// Flash pin bit positions
// ----------------------------------------------------------------
`define FSCTL_Q3            3
`define FSCTL_A0            0
`define FSCTL_A1            1
`define FSCTL_A6            6

`endif

//--- common/fsctl_pkg.sv
/*
  Types of the flash sequencing controller: operations, states and the
  structs that carry the flash pins and a pin cycle request.
  Assumes fsctl_consts.svh on the include path.
*/
`include "fsctl_consts.svh"

package fsctl_pkg;

  // ----------------------------------------------------------------
  // Operations and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ERASE_ADD, OP_PROTECT, OP_VERIFY, OP_UNPROTECT
  } fsctl_op_t;

  typedef enum logic [2:0] {
    S_IDLE, S_HV_ON, S_CHK1, S_WR, S_CHK2, S_RD, S_HV_OFF
  } fsctl_state_t;

  typedef enum logic [1:0] {
    C_IDLE, C_SETUP, C_STROBE, C_RECOV
  } fsctl_cyc_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   ce_n;
    logic                   oe_n;
    logic                   we_n;
    logic [`FSCTL_AW-1:0]   addr;
    logic [`FSCTL_DW-1:0]   dq_o;
    logic                   dq_oe;
  } fsctl_bus_t;

  typedef struct packed {
    logic                   is_write;
    logic [`FSCTL_AW-1:0]   addr;
    logic [`FSCTL_DW-1:0]   wdata;
    logic [`FSCTL_CW-1:0]   strobe_len;
  } fsctl_req_t;

endpackage

//--- logic/fsctl_cycle.sv
/*
  One flash pin cycle, read or write, with setup, strobe and recovery.
  Assumes a one-cycle start; a start in the last recovery cycle waits
  one idle cycle. dq_i is synchronous to hclk.
*/
`timescale 1ns/1ps
`include "fsctl_consts.svh"

module fsctl_cycle #(
  parameter int AH_CYC = `FSCTL_CEIL_CYC(`FSCTL_AH_NS)
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  start,
  input  fsctl_pkg::fsctl_req_t      req,
  input  wire logic [`FSCTL_DW-1:0]  dq_i,
  output fsctl_pkg::fsctl_bus_t      bus,
  output logic [`FSCTL_DW-1:0]       rdata,
  output logic                       done,
  output logic                       idle
);

  fsctl_pkg::fsctl_cyc_t   st_q, st_d;
  fsctl_pkg::fsctl_bus_t   bus_q, bus_d;
  logic [`FSCTL_CW-1:0]    cnt_q, cnt_d;
  logic [`FSCTL_DW-1:0]    rdata_q, rdata_d;
  logic                    pend_q, pend_d;
  wire                     last;

  assign last  = cnt_q <= `FSCTL_CW'(1);
  assign done  = (st_q == fsctl_pkg::C_RECOV) && last;
  assign idle  = st_q == fsctl_pkg::C_IDLE;
  assign bus   = bus_q;
  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // Cycle sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    bus_d   = bus_q;
    cnt_d   = cnt_q;
    rdata_d = rdata_q;
    pend_d  = pend_q || start;
    unique case (st_q)
      fsctl_pkg::C_IDLE: begin
        if (start || pend_q) begin
          pend_d      = 1'b0;
          bus_d.ce_n  = 1'b0;
          bus_d.addr  = req.addr;
          bus_d.dq_o  = req.wdata;
          bus_d.dq_oe = req.is_write;
          cnt_d       = req.strobe_len;
          st_d        = fsctl_pkg::C_SETUP;
        end
      end
      fsctl_pkg::C_SETUP: begin
        if (bus_q.dq_oe) begin
          bus_d.we_n = 1'b0;
        end else begin
          bus_d.oe_n = 1'b0;
        end
        st_d = fsctl_pkg::C_STROBE;
      end
      fsctl_pkg::C_STROBE: begin
        if (last) begin
          if (!bus_q.dq_oe) begin
            rdata_d = dq_i;
          end
          bus_d.we_n = 1'b1;
          bus_d.oe_n = 1'b1;
          cnt_d      = `FSCTL_CW'(AH_CYC);
          st_d       = fsctl_pkg::C_RECOV;
        end else begin
          cnt_d = cnt_q - `FSCTL_CW'(1);
        end
      end
      fsctl_pkg::C_RECOV: begin
        if (last) begin
          bus_d.ce_n  = 1'b1;
          bus_d.dq_oe = 1'b0;
          st_d        = fsctl_pkg::C_IDLE;
        end else begin
          cnt_d = cnt_q - `FSCTL_CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= fsctl_pkg::C_IDLE;
      bus_q   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
      cnt_q   <= '0;
      rdata_q <= '0;
      pend_q  <= 1'b0;
    end else begin
      pend_q  <= pend_d;
      st_q    <= st_d;
      bus_q   <= bus_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_we_gate;
    @(posedge hclk) disable iff (!hresetn)
      !bus_q.we_n |-> !bus_q.ce_n && bus_q.oe_n && bus_q.dq_oe;
  endproperty
  a_we_gate: assert property (p_we_gate) else $error("write strobe outside write gate");

  property p_we_release;
    @(posedge hclk) disable iff (!hresetn)
      $rose(bus_q.we_n) |-> !bus_q.ce_n [*2];
  endproperty
  a_we_release: assert property (p_we_release) else $error("chip select left too early");

endmodule // fsctl_cycle

//--- tb/fsctl_flash_model.sv
/*
  Behavioural flash device: erase window flag, sector protect, verify.
  Assumes the controller's registered pin levels on fsctl_bus_t.
*/
`timescale 1ns/1ps
`include "fsctl_consts.svh"

module fsctl_flash_model #(
  parameter int          WIN_NS  = 2000,
  parameter logic [15:0] ID_CODE = 16'h00A5  // Arbitrary value
) (
  input  fsctl_pkg::fsctl_bus_t    bus,
  input  wire logic                hv_a9,
  input  wire logic                hv_oe,
  input  wire logic                hv_reset,
  output logic [`FSCTL_DW-1:0]     dq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // power up in read mode
  logic [15:0] prot     = 16'h0000;
  logic        win_q3   = 1'b0;
  logic        win_open = 1'b0;
  logic [15:0] last     = 16'h0000;
  logic [15:0] val;
  realtime     t_fall   = 0;
  wire  [3:0]  sec      = bus.addr[19:16];

  // ----------------------------------------------------------------
  // Reads
  // ----------------------------------------------------------------
  // status and verify data
  assign val = !hv_a9 ? {12'h000, win_q3, 3'h0} :
               bus.addr[`FSCTL_A1] ? {15'h0000, prot[sec]} : ID_CODE;
  assign dq = (!bus.ce_n && !bus.oe_n) ? val : ~last;
  always @(posedge bus.oe_n) last = val;
  always @(negedge bus.we_n) t_fall = $realtime;

  // ----------------------------------------------------------------
  // Writes
  // ----------------------------------------------------------------
  // strobe decode
  always @(posedge bus.we_n) begin
    if ($realtime - t_fall >= 5.0 && !bus.ce_n) begin
      if (hv_a9 && hv_oe) begin
        if (bus.addr[`FSCTL_A6]) prot = 16'h0000;
        else prot[sec] = 1'b1;
      end else if (bus.oe_n && bus.dq_o[7:0] == 8'h30 && !win_q3
                   && (!prot[sec] || hv_reset)) begin
        if (!win_open) begin
          win_open = 1'b1;
          win_q3 <= #(WIN_NS) 1'b1;
        end
      end
    end
  end
endmodule // fsctl_flash_model

//--- tb/fsctl_top_test.sv
/*
  Testbench of the flash sequencer: AHB tasks and op sequences.
  Assumes fsctl_flash_model on the flash pins.
*/
`timescale 1ns/1ps
`include "fsctl_consts.svh"

module fsctl_top_test;
  logic                  hclk    = 1'b0;
  logic                  hresetn = 1'b0;
  logic                  hsel    = 1'b0;
  logic [31:0]           haddr   = 32'h0;
  logic [31:0]           hwdata  = 32'h0;
  logic [1:0]            htrans  = 2'h0;
  logic                  hwrite  = 1'b0;
  logic [2:0]            hsize   = 3'h2;
  logic [31:0]           hrdata, rd;
  logic                  hreadyout, hresp, hv_a9, hv_oe, hv_reset;
  logic [15:0]           dq_i;
  fsctl_pkg::fsctl_bus_t flash_bus;
  int                    n_fail  = 0;
  int                    compares = 0;

  always #10 hclk = ~hclk;

  fsctl_top #(.PROT_CYC(8), .HV_CYC(4)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .flash_bus(flash_bus), .dq_i(dq_i), .hv_a9(hv_a9),
    .hv_oe(hv_oe), .hv_reset(hv_reset));
  fsctl_flash_model #(.WIN_NS(5000)) flash (.bus(flash_bus), .hv_a9(hv_a9),
    .hv_oe(hv_oe), .hv_reset(hv_reset), .dq(dq_i));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic run(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    ahb(1'b1, `FSCTL_REG_ADDR, {12'h000, a});
    ahb(1'b1, `FSCTL_REG_WDATA, {16'h0000, d});
    ahb(1'b1, `FSCTL_REG_CTRL, {23'h000000, 1'b1, 5'h00, op});
    do begin
      ahb(1'b0, `FSCTL_REG_STATUS, 32'h0);
      n++;
    end while (rd[`FSCTL_ST_BUSY] !== 1'b0 && n < 500);
    if (rd[`FSCTL_ST_BUSY] !== 1'b0) begin
      n_fail++;
      $display("MISMATCH %0t operation never finished", $time);
      test_done();
    end
  endtask

  task automatic rdata_is(input logic [31:0] exp);
    ahb(1'b0, `FSCTL_REG_RDATA, 32'h0);
    cmp(rd, exp);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    cmp({29'h0, flash_bus.ce_n, flash_bus.we_n, hv_a9}, 32'h6);
    cmp({29'h0, hv_oe, hresp, hreadyout}, 32'h1);
    @(posedge hclk);
    ahb(1'b1, `FSCTL_REG_ADDR, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    cmp(rd, 32'h0);
    ahb(1'b0, `FSCTL_REG_ADDR, 32'h0);
    cmp(rd, 32'h000FFFFF);
    for (int op = 6; op < 8; op++) begin
      run(op[2:0], 20'h00000, 16'h0000);
      cmp({31'h0, rd[`FSCTL_ST_REJECT]}, 32'h1);
    end
    run(3'h5, 20'h30000, 16'h0000);
    cmp({31'h0, rd[`FSCTL_ST_REJECT]}, 32'h1);
    run(3'h4, 20'h30000, 16'h0000);
    rdata_is(32'h0);
    run(3'h3, 20'h30000, 16'h0000);
    run(3'h4, 20'h30000, 16'h0000);
    rdata_is(32'h1);
    ahb(1'b1, `FSCTL_REG_MODE, 32'h1);
    ahb(1'b0, 8'h20, 32'h0);
    ahb(1'b0, `FSCTL_REG_STATUS, 32'h0);
    cmp({30'h0, rd[`FSCTL_ST_TEMP], hv_reset}, 32'h3);
    ahb(1'b1, `FSCTL_REG_MODE, 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    cmp({31'h0, hv_reset}, 32'h0);
    run(3'h5, 20'h30000, 16'h0000);
    cmp({31'h0, rd[`FSCTL_ST_REJECT]}, 32'h0);
    run(3'h4, 20'h30000, 16'h0000);
    rdata_is(32'h0);
    run(3'h2, 20'h10000, 16'h0030);
    cmp({31'h0, rd[`FSCTL_ST_REJECT]}, 32'h0);
    run(3'h2, 20'h20000, 16'h0030);
    cmp({31'h0, rd[`FSCTL_ST_REJECT]}, 32'h0);
    repeat (400) @(posedge hclk);
    run(3'h2, 20'h40000, 16'h0030);
    cmp({31'h0, rd[`FSCTL_ST_REJECT]}, 32'h1);
    run(3'h0, 20'h40000, 16'h0000);
    rdata_is(32'h8);
    test_done();
  end

  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule // fsctl_top_test
